// File: verilog/tfc_tx_fifo_frame_end.sv
// Operation
// (R1) Transmit data request holds while empty slots exceed the programmed level.
// (R2) Level 31 requests only when the transmit queue is fully empty.
// (R3) Level 01 requests once two queue slots are empty.
// (R4) Transmit interrupt control register shows the current empty-slot count.
// (R5) Clearing the transmit data enable stops the request.
// (R6) Writing the daisy chain register clears the pending flag.
// (R7) Load-count command copies the reload value into the character counter.
// (R8) Word write at count 0001 queues only the low byte.
// (R9) Character taking the count from 1 to 0 is tagged end of frame.
// (R10) Purge or load-count command arms control block reception.
// (R11) Control block is 32 bits; its last 16 bits become the count.
// (R12) A new control block is expected after each frame end.
// (R13) End-of-frame command tags the next written character.
// (R14) Host without counter writes the second-last character as a byte.
// (R15) Under-service flag clears by daisy chain upper write or command.
// (R16) Host clears the under-service flag at end of its service.
// (R17) After reset pin, next write goes to bus configuration register.
// (R18) Channel-select address line picks wait or acknowledge handshake.
// (R19) Soft reset: write reset bit one, then zero, resets channel.
// (R20) After reset registers read zero except mirrored pin bits and the empty-status bits.
// (R21) After reset empty bit and 32-empty level bit read one.
//
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.
module tfc_tx_fifo_frame_end
    import tfc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic tx_ready,
    output logic tx_valid,
    output logic [7:0] tx_char,
    output logic tx_eof,
    input wire logic [1:0] req_pin_n,
    output logic tx_data_req,
    output logic tx_int_req,
    output logic wait_ack_mode
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction : hit

    logic dp_valid_ff, dp_write_ff, dp_chsel_ff;
    logic [7:0] dp_addr_ff;
    logic [31:0] hrdata_ff;
    logic [31:0] rd_val;
    logic hi_pend_ff;
    logic [7:0] hi_char_ff;
    logic bcr_wait_ff, wait_mode_ff, soft_rst_ff;
    logic [15:0] bcr_ff;
    logic [4:0] req_level_ff;
    logic tx_ie_ff, pending_ff, ius_ff;
    logic [15:0] cnt_ff, reload_ff;
    logic eof_next_ff, tcb_mode_ff, expect_tcb_ff, tcb_half_ff;
    logic [FIFO_AW-1:0] wr_ptr_ff, rd_ptr_ff;
    logic [5:0] mem_cnt_ff, occ_ff;
    logic fetch_ff, tx_valid_ff, tx_eof_ff;
    logic [7:0] tx_char_ff;
    logic [1:0] pin_meta_ff, pin_sync_ff;

    logic addr_phase, wr_now, reg_wr, chan_rst;
    logic [15:0] wd;
    logic wr_cmd, wr_txb, wr_txw, wr_tx_int_ctrl_reg, wr_tx_cmd_status_reg, wr_icr, wr_daisy_chain_ctrl_reg, wr_reload, wr_mode;
    logic cmd_go, purge, load_cnt, reset_ius;
    logic tag_now, push_lo, hi_go, push, fetch, tx_pop, tcb_word, tcb_done, cond;
    logic [5:0] empty_cnt;
    logic [ENTRY_W-1:0] push_entry;

    tfc_mem_if mif();

    tfc_queue_mem u_mem (
        .hclk(hclk),
        .hresetn(hresetn),
        .port(mif.mem)
    );

    // Address phase taken only on a ready, non-idle cycle
    assign addr_phase = hsel & hready & htrans[1];
    assign wd = hwdata[15:0];
    assign wr_now = dp_valid_ff & dp_write_ff & !hi_pend_ff;
    assign reg_wr = wr_now & !bcr_wait_ff;
    assign chan_rst = soft_rst_ff;

    // Write decode from the latched data-phase address
    assign wr_cmd = reg_wr & hit(dp_addr_ff, ADDR_CHAN_CMD);
    assign wr_txb = reg_wr & hit(dp_addr_ff, ADDR_TX_BYTE);
    assign wr_txw = reg_wr & hit(dp_addr_ff, ADDR_TX_WORD);
    assign wr_tx_int_ctrl_reg = reg_wr & hit(dp_addr_ff, ADDR_TX_INT_CTRL);
    assign wr_tx_cmd_status_reg = reg_wr & hit(dp_addr_ff, ADDR_TX_CMD_STATUS);
    assign wr_icr = reg_wr & hit(dp_addr_ff, ADDR_INT_CTRL);
    assign wr_daisy_chain_ctrl_reg = reg_wr & hit(dp_addr_ff, ADDR_DAISY_CHAIN);
    assign wr_reload = reg_wr & hit(dp_addr_ff, ADDR_COUNT_RELOAD);
    assign wr_mode = reg_wr & hit(dp_addr_ff, ADDR_TX_MODE);

    // Commands ignored while the channel sits in soft reset
    assign cmd_go = wr_cmd & !wd[SOFT_RESET_BIT] & !soft_rst_ff;
    assign purge = cmd_go & (wd[15:CMD_LSB] == CMD_PURGE_TX);
    assign load_cnt = cmd_go & (wd[15:CMD_LSB] == CMD_LOAD_COUNT);
    assign reset_ius = cmd_go & (wd[15:CMD_LSB] == CMD_RESET_IUS);

    // Character entry and end-of-frame tagging
    assign tag_now = eof_next_ff | (cnt_ff == 16'h0001); // [R9] [R13]
    assign push_lo = (wr_txb | wr_txw) & !expect_tcb_ff & (occ_ff != FIFO_DEPTH);
    // High byte dropped once the low byte closed the frame
    assign hi_go = wr_txw & !expect_tcb_ff & (occ_ff < FIFO_DEPTH - 6'h01) & !tag_now; // [R8]
    assign push = push_lo | hi_pend_ff;
    assign push_entry = {tag_now, hi_pend_ff ? hi_char_ff : wd[7:0]};
    assign tcb_word = wr_txw & expect_tcb_ff;
    assign tcb_done = tcb_word & tcb_half_ff;

    // Queue drain: one fetch in flight, output slot must be free
    assign tx_pop = tx_valid_ff & tx_ready;
    assign fetch = (mem_cnt_ff != 6'h00) & !fetch_ff & (!tx_valid_ff | tx_ready);
    assign mif.we = push;
    assign mif.waddr = wr_ptr_ff;
    assign mif.wdata = push_entry;
    assign mif.raddr = rd_ptr_ff;

    // Request threshold is level plus one empty slot
    assign empty_cnt = FIFO_DEPTH - occ_ff;
    assign cond = empty_cnt > {1'b0, req_level_ff}; // [R1] [R2] [R3]
    assign tx_data_req = cond & tx_ie_ff; // [R5]
    assign tx_int_req = pending_ff & tx_ie_ff & !ius_ff;

    assign hreadyout = !hi_pend_ff;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign tx_valid = tx_valid_ff;
    assign tx_char = tx_char_ff;
    assign tx_eof = tx_eof_ff;
    assign wait_ack_mode = wait_mode_ff;

    // Data-phase capture; frozen while a wait state runs
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_valid_ff <= 1'b0;
            dp_write_ff <= 1'b0;
            dp_chsel_ff <= 1'b0;
            dp_addr_ff <= 8'h00;
        end
        else if (hreadyout)
        begin
            dp_valid_ff <= addr_phase;
            dp_write_ff <= hwrite;
            dp_chsel_ff <= haddr[CHAN_SEL_ADDR_BIT];
            dp_addr_ff <= haddr[7:0];
        end
    end

    // Read data sampled at the address phase, so reads need no wait
    always_comb
    begin
        rd_val = 32'h0000_0000;
        if (hit(haddr[7:0], ADDR_CHAN_CMD))
            rd_val = {21'h000000, soft_rst_ff, 10'h000};
        else if (hit(haddr[7:0], ADDR_TX_INT_CTRL))
            rd_val = {18'h00000, empty_cnt, 3'h0, req_level_ff}; // [R4] [R21]
        else if (hit(haddr[7:0], ADDR_TX_CMD_STATUS))
            rd_val = {29'h00000000, eof_next_ff, cond, occ_ff == 6'h00}; // [R21]
        else if (hit(haddr[7:0], ADDR_INT_CTRL))
            rd_val = {31'h00000000, tx_ie_ff};
        else if (hit(haddr[7:0], ADDR_DAISY_CHAIN))
            rd_val = {23'h000000, ius_ff, 7'h00, pending_ff};
        else if (hit(haddr[7:0], ADDR_CHAR_COUNTER))
            rd_val = {16'h0000, cnt_ff};
        else if (hit(haddr[7:0], ADDR_COUNT_RELOAD))
            rd_val = {16'h0000, reload_ff};
        else if (hit(haddr[7:0], ADDR_BUS_CONFIG))
            rd_val = {16'h0000, bcr_ff};
        else if (hit(haddr[7:0], ADDR_TX_MODE))
            rd_val = {29'h00000000, tcb_half_ff, expect_tcb_ff, tcb_mode_ff};
        else if (hit(haddr[7:0], ADDR_CHAN_STATUS))
            rd_val = {30'h00000000, pin_sync_ff}; // [R20]
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_ff <= 32'h0000_0000;
        else if (addr_phase && !hwrite)
            hrdata_ff <= rd_val;
    end

    // Second byte of a word write goes in one wait state later
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hi_pend_ff <= 1'b0;
            hi_char_ff <= 8'h00;
        end
        else if (hi_pend_ff)
            hi_pend_ff <= 1'b0;
        else if (hi_go)
        begin
            hi_pend_ff <= 1'b1;
            hi_char_ff <= wd[15:8];
        end
    end

    // First write after the reset pin lands in bus configuration
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bcr_wait_ff <= 1'b1;
            bcr_ff <= BUS_CONFIG_RESET;
            wait_mode_ff <= 1'b0;
        end
        else if (wr_now && bcr_wait_ff)
        begin
            bcr_wait_ff <= 1'b0; // [R17]
            bcr_ff <= wd;
            wait_mode_ff <= dp_chsel_ff; // [R18]
        end
    end

    // Reset bit holds the channel cleared until a zero write releases it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            soft_rst_ff <= 1'b0;
        else if (wr_cmd)
            soft_rst_ff <= wd[SOFT_RESET_BIT]; // [R19]
    end

    // Pin mirrors; first stage feeds only the second
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_meta_ff <= 2'h0;
            pin_sync_ff <= 2'h0;
        end
        else
        begin
            pin_meta_ff <= req_pin_n;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // Interrupt controls, pending and under-service flags
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            req_level_ff <= REQ_LEVEL_RESET;
            tx_ie_ff <= 1'b0;
            pending_ff <= 1'b0;
            ius_ff <= 1'b0;
        end
        else if (chan_rst)
        begin
            req_level_ff <= REQ_LEVEL_RESET; // [R19] [R20]
            tx_ie_ff <= 1'b0;
            pending_ff <= 1'b0;
            ius_ff <= 1'b0;
        end
        else
        begin
            if (wr_tx_int_ctrl_reg)
                req_level_ff <= wd[4:0];
            if (wr_icr)
                tx_ie_ff <= wd[0];
            // Set wins over the clearing write
            if (tx_data_req)
                pending_ff <= 1'b1;
            else if (wr_daisy_chain_ctrl_reg)
                pending_ff <= 1'b0; // [R6]
            if (reset_ius)
                ius_ff <= 1'b0; // [R15]
            else if (wr_daisy_chain_ctrl_reg && wd[IUS_WRITE_BIT])
                ius_ff <= wd[IUS_VALUE_BIT]; // [R15]
        end
    end

    // Counter, end-of-frame command and control block tracking
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_ff <= COUNT_RESET;
            reload_ff <= COUNT_RESET;
            eof_next_ff <= 1'b0;
            tcb_mode_ff <= 1'b0;
            expect_tcb_ff <= 1'b0;
            tcb_half_ff <= 1'b0;
        end
        else if (chan_rst)
        begin
            cnt_ff <= COUNT_RESET;
            reload_ff <= COUNT_RESET;
            eof_next_ff <= 1'b0;
            tcb_mode_ff <= 1'b0;
            expect_tcb_ff <= 1'b0;
            tcb_half_ff <= 1'b0;
        end
        else
        begin
            if (wr_reload)
                reload_ff <= wd;
            if (wr_mode)
                tcb_mode_ff <= wd[0];
            if (load_cnt)
                cnt_ff <= reload_ff; // [R7]
            else if (tcb_done)
                cnt_ff <= wd; // [R11]
            else if (push && cnt_ff != 16'h0000)
                cnt_ff <= cnt_ff - 16'h0001; // [R9]
            if (wr_tx_cmd_status_reg && wd[15:8] == END_OF_FRAME_CMD)
                eof_next_ff <= 1'b1; // [R13]
            else if (push)
                eof_next_ff <= 1'b0;
            if (purge || load_cnt)
                expect_tcb_ff <= tcb_mode_ff; // [R10]
            else if (tcb_done)
                expect_tcb_ff <= 1'b0;
            else if (push && tag_now && tcb_mode_ff)
                expect_tcb_ff <= 1'b1; // [R12]
            if (purge || load_cnt)
                tcb_half_ff <= 1'b0;
            else if (tcb_word)
                tcb_half_ff <= !tcb_half_ff; // [R11]
        end
    end

    // Queue pointers and occupancy
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            mem_cnt_ff <= 6'h00;
            occ_ff <= 6'h00;
        end
        else if (chan_rst || purge)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            mem_cnt_ff <= 6'h00;
            occ_ff <= 6'h00; // [R21]
        end
        else
        begin
            if (push)
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            if (fetch)
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            mem_cnt_ff <= mem_cnt_ff + {5'h00, push} - {5'h00, fetch};
            occ_ff <= occ_ff + {5'h00, push} - {5'h00, tx_pop};
        end
    end

    // Output slot toward the transmitter, tag travels with the character
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fetch_ff <= 1'b0;
            tx_valid_ff <= 1'b0;
            tx_char_ff <= 8'h00;
            tx_eof_ff <= 1'b0;
        end
        else if (chan_rst || purge)
        begin
            fetch_ff <= 1'b0;
            tx_valid_ff <= 1'b0;
        end
        else
        begin
            fetch_ff <= fetch;
            if (fetch_ff)
            begin
                tx_valid_ff <= 1'b1;
                tx_char_ff <= mif.rdata[7:0];
                tx_eof_ff <= mif.rdata[8]; // [R9]
            end
            else if (tx_pop)
                tx_valid_ff <= 1'b0;
        end
    end

    full_empty_a: assert property ((tx_ie_ff && req_level_ff == 5'h1F && occ_ff != 6'h00)
        |-> !tx_data_req) else $error("level 31 request with data queued"); // [R2]
    two_slot_a: assert property ((tx_ie_ff && req_level_ff == 5'h01 && occ_ff <= 6'h1E)
        |-> tx_data_req) else $error("level 1 request missing"); // [R3] [R1]
    ie_off_a: assert property ((wr_icr && !wd[0] && !chan_rst) |=> !tx_data_req)
        else $error("request after enable cleared"); // [R5]
    pend_clr_a: assert property ((wr_daisy_chain_ctrl_reg && !tx_data_req && !chan_rst) |=> !pending_ff)
        else $error("pending survived clearing write"); // [R6]
    load_cnt_a: assert property (load_cnt && !chan_rst |=> cnt_ff == $past(reload_ff))
        else $error("counter not loaded"); // [R7]
    last_pair_a: assert property ((wr_txw && !expect_tcb_ff && cnt_ff == 16'h0001 && !occ_ff[5])
        |=> hreadyout && cnt_ff == 16'h0000) else $error("high byte taken at count 1"); // [R8]
    tcb_load_a: assert property ((tcb_done && !load_cnt && !chan_rst)
        |=> cnt_ff == $past(wd) && !expect_tcb_ff) else $error("block count lost"); // [R11]
    bcr_first_a: assert property ((wr_now && bcr_wait_ff) |=> !bcr_wait_ff
        && wait_ack_mode == $past(dp_chsel_ff)) else $error("config write missed"); // [R17]
    soft_clear_a: assert property ($fell(soft_rst_ff) |-> occ_ff == 6'h00
        && cnt_ff == 16'h0000 && !tx_valid_ff) else $error("soft reset left state"); // [R19]
endmodule : tfc_tx_fifo_frame_end

// File: verilog/tfc_pkg.sv
package tfc_pkg;
    // Register byte addresses, one aligned word each
    localparam logic [7:0] ADDR_CHAN_CMD = 8'h00;
    localparam logic [7:0] ADDR_TX_BYTE = 8'h04;
    localparam logic [7:0] ADDR_TX_WORD = 8'h08;
    localparam logic [7:0] ADDR_TX_INT_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_TX_CMD_STATUS = 8'h10;
    localparam logic [7:0] ADDR_INT_CTRL = 8'h14;
    localparam logic [7:0] ADDR_DAISY_CHAIN = 8'h18;
    localparam logic [7:0] ADDR_CHAR_COUNTER = 8'h1C;
    localparam logic [7:0] ADDR_COUNT_RELOAD = 8'h20;
    localparam logic [7:0] ADDR_BUS_CONFIG = 8'h24;
    localparam logic [7:0] ADDR_TX_MODE = 8'h28;
    localparam logic [7:0] ADDR_CHAN_STATUS = 8'h2C;
    // Queue geometry
    localparam int FIFO_AW = 5;
    localparam int ENTRY_W = 9;
    localparam logic [5:0] FIFO_DEPTH = 6'h20;
    // Field positions
    localparam int SOFT_RESET_BIT = 10;
    localparam int CMD_LSB = 11;
    localparam int IUS_WRITE_BIT = 9;
    localparam int IUS_VALUE_BIT = 8;
    localparam int CHAN_SEL_ADDR_BIT = 6;
    // Command codes
    localparam logic [4:0] CMD_PURGE_TX = 5'h01;
    localparam logic [4:0] CMD_LOAD_COUNT = 5'h02;
    localparam logic [4:0] CMD_RESET_IUS = 5'h03;
    localparam logic [7:0] END_OF_FRAME_CMD = 8'h01;
    // Values after reset
    localparam logic [15:0] BUS_CONFIG_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [4:0] REQ_LEVEL_RESET = 5'h00;
endpackage : tfc_pkg

// File: verilog/tfc_mem_if.sv
interface tfc_mem_if;
    import tfc_pkg::*;
    logic we;
    logic [FIFO_AW-1:0] waddr;
    logic [ENTRY_W-1:0] wdata;
    logic [FIFO_AW-1:0] raddr;
    logic [ENTRY_W-1:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : tfc_mem_if

// File: verilog/tfc_queue_mem.sv
module tfc_queue_mem
    import tfc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    tfc_mem_if.mem port
);
    logic [ENTRY_W-1:0] mem_array [0:(1<<FIFO_AW)-1];
    logic [ENTRY_W-1:0] rdata_ff;

    // Storage has no reset; only written slots are ever fetched
    always_ff @(posedge hclk)
    begin
        if (port.we)
        begin
            mem_array[port.waddr] <= port.wdata;
        end
    end

    // Registered read, one cycle behind the address
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rdata_ff <= '0;
        end
        else
        begin
            rdata_ff <= mem_array[port.raddr];
        end
    end

    assign port.rdata = rdata_ff;
endmodule : tfc_queue_mem

// File: verification/tfc_tx_sink.sv
// Serial transmitter stand-in; takes characters only within a credit limit
module tfc_tx_sink
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic tx_valid,
    input wire logic [7:0] tx_char,
    input wire logic tx_eof,
    input wire logic slow,
    input wire logic [7:0] limit,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got_ff;
    logic pace_ff;
    logic [8:0] seen_q[$];

    // Record each taken character; slow mode offers ready only every other cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            got_ff <= 8'h00;
            pace_ff <= 1'b0;
            tx_ready <= 1'b0;
        end
        else
        begin
            pace_ff <= ~pace_ff;
            if (tx_valid && tx_ready)
            begin
                seen_q.push_back({tx_eof, tx_char});
                got_ff <= got_ff + 8'h01;
                tx_ready <= 1'b0;  // Credit recount needs a cycle
            end
            else
            begin
                tx_ready <= (got_ff < limit) && (!slow || pace_ff);
            end
        end
    end
endmodule : tfc_tx_sink

// File: verification/tfc_tx_fifo_frame_end_tb.sv
module tfc_tx_fifo_frame_end_tb
    import tfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, tx_ready, tx_valid, tx_eof;
    logic tx_data_req, tx_int_req, wait_ack_mode, slow;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, req_pin_n;
    logic [2:0] hsize;
    logic [7:0] tx_char, limit;
    logic [8:0] exp_q[$];
    int errors, n_compared;

    tfc_tx_fifo_frame_end tfc_tx_fifo_frame_end_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_char(tx_char), .tx_eof(tx_eof),
        .req_pin_n(req_pin_n), .tx_data_req(tx_data_req), .tx_int_req(tx_int_req),
        .wait_ack_mode(wait_ack_mode));
    tfc_tx_sink tfc_tx_sink_i (.hclk(hclk), .hresetn(hresetn), .tx_valid(tx_valid),
        .tx_char(tx_char), .tx_eof(tx_eof), .slow(slow), .limit(limit), .tx_ready(tx_ready));

    // Free-running bus clock
    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask : idle

    // Bounded wait so a stuck ready shows up as a mismatch, not a hang
    task automatic wait_rdy;
        int k;
        k = 0;
        do
        begin
            @(posedge hclk);
            k++;
        end
        while (hreadyout !== 1'b1 && k < 20);
        check(32'(k < 20), 32'h1, "ready wait");
    endtask : wait_rdy

    // One single AHB transfer; read data taken at the data-phase edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
        check(32'(hresp), 32'h0, "response");
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
        idle(1);  // Checks after a write see the settled register
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h00000000, r);
        check(r & m, e, "register read");
    endtask : rd

    // Let the sink drain, then compare every character and its frame-end mark
    task automatic flush;
        int k;
        limit <= 8'hFF;
        k = 0;
        while (tfc_tx_sink_i.seen_q.size() < exp_q.size() && k < 300)
        begin
            idle(1);
            k++;
        end
        idle(6);
        check(tfc_tx_sink_i.seen_q.size(), exp_q.size(), "char count");
        foreach (exp_q[i])
            check({23'h0, tfc_tx_sink_i.seen_q[i]}, {23'h0, exp_q[i]}, "char");
        tfc_tx_sink_i.seen_q.delete();
        exp_q.delete();
        limit <= 8'h00;
    endtask : flush

    task automatic t_reset;
        check(32'(tx_valid), 32'h0, "valid");
        wr(8'h54, 32'h0000A5C3);
        check(32'(wait_ack_mode), 32'h1, "handshake");
        rd(ADDR_BUS_CONFIG, 32'h0000FFFF, 32'h0000A5C3);
        rd(ADDR_INT_CTRL, 32'hFFFFFFFF, 32'h0);
        rd(ADDR_TX_INT_CTRL, 32'hFFFFFFFF, 32'h00002000);
        rd(ADDR_TX_CMD_STATUS, 32'h1, 32'h1);
        rd(ADDR_CHAR_COUNTER, 32'hFFFFFFFF, 32'h0);
        rd(ADDR_COUNT_RELOAD, 32'hFFFFFFFF, 32'h0);
        rd(ADDR_TX_MODE, 32'hFFFFFFFF, 32'h0);
        rd(ADDR_CHAN_STATUS, 32'h3, 32'h2);
        rd(8'h30, 32'hFFFFFFFF, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_levels;
        wr(ADDR_INT_CTRL, 32'h1);
        wr(ADDR_TX_INT_CTRL, 32'h1F);
        idle(2);
        check(32'(tx_data_req), 32'h1, "level 31 empty");
        check(32'(tx_int_req), 32'h1, "int request");
        wr(ADDR_DAISY_CHAIN, 32'h300);
        check(32'(tx_int_req), 32'h0, "under service");
        wr(ADDR_CHAN_CMD, {16'h0, CMD_RESET_IUS, 11'h0});
        check(32'(tx_int_req), 32'h1, "cmd clears");
        wr(ADDR_DAISY_CHAIN, 32'h300);
        wr(ADDR_DAISY_CHAIN, 32'h200);
        check(32'(tx_int_req), 32'h1, "daisy clears");
        wr(ADDR_TX_BYTE, 32'h10);
        wr(ADDR_TX_BYTE, 32'h11);
        idle(4);
        check(32'(tx_data_req), 32'h0, "level 31 not empty");
        wr(ADDR_DAISY_CHAIN, 32'h0);
        check(32'(tx_int_req), 32'h0, "pending cleared");
        for (int i = 0; i < 40; i++)
            wr(ADDR_TX_BYTE, i);
        rd(ADDR_TX_INT_CTRL, 32'h3F00, 32'h0);
        wr(ADDR_TX_INT_CTRL, 32'h01);
        idle(2);
        check(32'(tx_data_req), 32'h0, "level 1 full");
        limit <= tfc_tx_sink_i.got_ff + 8'h01;
        idle(10);
        check(32'(tx_data_req), 32'h0, "level 1 one empty");
        limit <= tfc_tx_sink_i.got_ff + 8'h01;
        idle(10);
        check(32'(tx_data_req), 32'h1, "level 1 two empty");
        rd(ADDR_TX_INT_CTRL, 32'h3F1F, 32'h0201);
        check(32'(tx_int_req), 32'h1, "pending again");
        wr(ADDR_INT_CTRL, 32'h0);
        check(32'(tx_data_req), 32'h0, "disabled");
        check(32'(tx_int_req), 32'h0, "disabled int");
        wr(ADDR_CHAN_CMD, {16'h0, CMD_PURGE_TX, 11'h0});
        idle(3);
        check(32'(tx_valid), 32'h0, "purged");
        rd(ADDR_TX_INT_CTRL, 32'h3F00, 32'h2000);
        tfc_tx_sink_i.seen_q.delete();
        $display("test levels done");
    endtask : t_levels

    task automatic t_counter;
        wr(ADDR_COUNT_RELOAD, 32'h3);
        wr(ADDR_CHAN_CMD, {16'h0, CMD_LOAD_COUNT, 11'h0});
        rd(ADDR_CHAR_COUNTER, 32'hFFFF, 32'h3);
        wr(ADDR_TX_WORD, 32'hBBAA);
        wr(ADDR_TX_WORD, 32'hDDCC);
        rd(ADDR_CHAR_COUNTER, 32'hFFFF, 32'h0);
        wr(ADDR_TX_BYTE, 32'hEE);
        exp_q = '{9'h0AA, 9'h0BB, 9'h1CC, 9'h0EE};
        flush();
        wr(ADDR_TX_BYTE, 32'h11);
        wr(ADDR_TX_CMD_STATUS, 32'h0100);
        rd(ADDR_TX_CMD_STATUS, 32'h4, 32'h4);
        wr(ADDR_TX_WORD, 32'h5544);
        exp_q = '{9'h011, 9'h144};
        flush();
        rd(ADDR_TX_CMD_STATUS, 32'h4, 32'h0);
        $display("test counter done");
    endtask : t_counter

    task automatic t_block;
        slow <= 1'b1;
        wr(ADDR_TX_MODE, 32'h1);
        for (int i = 0; i < 2; i++)
        begin
            wr(ADDR_CHAN_CMD, {16'h0, i ? CMD_LOAD_COUNT : CMD_PURGE_TX, 11'h0});
            rd(ADDR_TX_MODE, 32'h2, 32'h2);
            wr(ADDR_TX_BYTE, 32'h99);
            wr(ADDR_TX_WORD, 32'h0);
            wr(ADDR_TX_WORD, 32'h1);
            rd(ADDR_CHAR_COUNTER, 32'hFFFF, 32'h1);
            wr(ADDR_TX_WORD, 32'h5A55 + i);
        end
        wr(ADDR_TX_WORD, 32'hFFFF);
        wr(ADDR_TX_WORD, 32'h2);
        rd(ADDR_CHAR_COUNTER, 32'hFFFF, 32'h2);
        wr(ADDR_TX_WORD, 32'h6766);
        exp_q = '{9'h155, 9'h156, 9'h066, 9'h167};
        flush();
        wr(ADDR_TX_MODE, 32'h0);
        wr(ADDR_CHAN_CMD, {16'h0, CMD_PURGE_TX, 11'h0});
        slow <= 1'b0;
        $display("test block done");
    endtask : t_block

    task automatic t_soft;
        wr(ADDR_COUNT_RELOAD, 32'h5);
        wr(ADDR_TX_INT_CTRL, 32'h3);
        wr(ADDR_INT_CTRL, 32'h1);
        wr(ADDR_TX_BYTE, 32'h42);
        idle(4);
        check(32'(tx_valid), 32'h1, "held char");
        wr(ADDR_CHAN_CMD, 32'h400);
        wr(ADDR_CHAN_CMD, 32'h0);
        idle(2);
        check(32'(tx_valid), 32'h0, "soft reset char");
        check(32'(wait_ack_mode), 32'h1, "handshake kept");
        rd(ADDR_COUNT_RELOAD, 32'hFFFFFFFF, 32'h0);
        rd(ADDR_INT_CTRL, 32'hFFFFFFFF, 32'h0);
        rd(ADDR_TX_INT_CTRL, 32'hFFFFFFFF, 32'h00002000);
        rd(ADDR_TX_CMD_STATUS, 32'h1, 32'h1);
        $display("test soft reset done");
    endtask : t_soft

    // Watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        idle(20000);
        errors++;
        $display("unexpected at %0t: run did not finish", $time);
        wrap_up();
    end

    // Main sequence
    initial
    begin
        errors = 0;
        n_compared = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        req_pin_n = 2'h2;
        slow = 1'b0;
        limit = 8'h00;
        idle(10);
        hresetn <= 1'b1;
        idle(1);
        t_reset();
        t_levels();
        t_counter();
        t_block();
        t_soft();
        wrap_up();
    end
endmodule : tfc_tx_fifo_frame_end_tb
